// >>> verilog/nto_defines.svh
`ifndef NTO_DEFINES_SVH
`define NTO_DEFINES_SVH
// Function
// - A three-bit auto-update mode field per page picks the triggering byte.
// - Mode zero: tuning-word writes only store, never start a load.
// - Modes one to six load after writing byte zero to five.
// - With sync-load set, next rising sync edge loads word and resets NCO.
// - Each load updates main tuning word and calibration tone word together.
// - Read-only acknowledge reads one once the load has completed.
// - Request bit loads on a zero-to-one write; writing zero clears acknowledge unless a load is in its done state.
// - Plain mode: NCO advances by the 48-bit tuning word per clock.
// - Modulus mode adds a fractional carry of delta over modulus.
// - All controls and bytes are held per datapath, chosen by page bits.
// - A per-page modulus enable switches plain and modulus accumulation.
`define NTO_AW 12
`define NTO_ADDR_PAGE 12'h008
`define NTO_ADDR_NCO_CTRL 12'h112
`define NTO_ADDR_UPDATE 12'h113
`define NTO_ADDR_FTW0 12'h114
`define NTO_ADDR_FTW5 12'h119
`define NTO_PAGE_LSB 6
`define NTO_PAGE_BITS 2
`define NTO_FTW_BYTES 6
`define NTO_FTW_W 48
`define NTO_MODE_LSB 4
`define NTO_MODE_W 3
`define NTO_MODE_NONE 3'h0
`define NTO_MODE_BYTE_OFS 3'h1
`define NTO_UPD_SYNC_BIT 2
`define NTO_UPD_ACK_BIT 1
`define NTO_UPD_REQ_BIT 0
`define NTO_CTRL_MOD_BIT 2
`define NTO_RST_BYTE 8'h00
`endif

// >>> verilog/nto_pkg.sv
package nto_pkg;
   typedef enum logic [1:0] {
      NTO_LD_IDLE = 2'h0,
      NTO_LD_XFER = 2'h1,
      NTO_LD_DONE = 2'h3
   } nto_ld_state_t;
   typedef logic [7:0] nto_byte_t;
endpackage

// >>> verilog/nto_sync.sv
`timescale 1ns/1ps
module nto_sync (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic rise
);
   logic s1_ff, s2_ff, s3_ff, level_ff;
   logic nxt_level;

   // The level moves only once the second and third stages agree.
   always_comb begin
      nxt_level = level_ff;
      if (s2_ff == s3_ff) begin
         nxt_level = s3_ff;
      end
      rise = nxt_level & ~level_ff & (s2_ff == s3_ff);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         level_ff <= 1'b0;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         level_ff <= nxt_level;
      end
   end
endmodule

// >>> verilog/nto_accum.sv
`timescale 1ns/1ps
module nto_accum #(
   parameter int FTW_W = 48,
   parameter int MOD_W = 32
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic load_pulse,
   input wire logic reset_phase,
   input wire logic [FTW_W-1:0] next_word,
   input wire logic modulus_enable,
   input wire logic [MOD_W-1:0] acc_delta,
   input wire logic [MOD_W-1:0] acc_modulus,
   output logic [FTW_W-1:0] active_word,
   output logic [FTW_W-1:0] phase
);
   logic [FTW_W-1:0] word_ff, phase_ff, nxt_word, nxt_phase;
   logic [MOD_W-1:0] frac_ff, nxt_frac;
   logic [MOD_W:0] frac_sum;
   logic [MOD_W:0] carry;

   always_comb begin
      frac_sum = {1'b0, frac_ff} + {1'b0, acc_delta};
      carry = '0;
      nxt_frac = '0;
      if (modulus_enable) begin
         nxt_frac = frac_sum[MOD_W-1:0];
         // A zero modulus cannot divide, so no carry is added and the fraction keeps summing.
         // Delta may exceed the modulus, so one edge can carry several.
         if (acc_modulus != '0) begin
            carry = frac_sum / {1'b0, acc_modulus};
            nxt_frac = MOD_W'(frac_sum % {1'b0, acc_modulus});
         end
      end
      nxt_phase = FTW_W'(phase_ff + word_ff + FTW_W'(carry));
      nxt_word = word_ff;
      if (load_pulse) begin
         nxt_word = next_word;
         if (reset_phase) begin
            nxt_phase = '0;
            nxt_frac = '0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_ff <= '0;
         phase_ff <= '0;
         frac_ff <= '0;
      end else begin
         word_ff <= nxt_word;
         phase_ff <= nxt_phase;
         frac_ff <= nxt_frac;
      end
   end

   assign active_word = word_ff;
   assign phase = phase_ff;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_plain_step: assert property (
      (!modulus_enable && !load_pulse) |=>
      phase_ff == FTW_W'($past(phase_ff) + $past(word_ff)))
      else $error("plain accumulation step wrong");
   chk_mod_carry: assert property (
      (modulus_enable && carry != '0 && !load_pulse) |=>
      phase_ff == FTW_W'($past(phase_ff) + $past(word_ff) +
                         FTW_W'($past(carry))))
      else $error("modulus carry not added");

   localparam int SPLIT_W = 2 * MOD_W + 1;
   chk_mod_split: assert property (
      (modulus_enable && acc_modulus != '0) |->
      SPLIT_W'(carry) * SPLIT_W'(acc_modulus) + SPLIT_W'(nxt_frac) ==
      SPLIT_W'(frac_sum) && nxt_frac < acc_modulus)
      else $error("modulus split of the fraction wrong");
endmodule

// >>> verilog/nto_top.sv
`timescale 1ns/1ps
`include "nto_defines.svh"
module nto_top
   import nto_pkg::*;
#(
   parameter int NUM_PATHS = 2,
   parameter int FTW_W = `NTO_FTW_W,
   parameter int MOD_W = 32
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [`NTO_AW-1:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rd_data,
   input wire logic sync_edge_in,
   input wire logic [MOD_W-1:0] acc_delta,
   input wire logic [MOD_W-1:0] acc_modulus,
   output logic [NUM_PATHS*FTW_W-1:0] nco_phase,
   output logic [NUM_PATHS*FTW_W-1:0] main_tuning_word,
   output logic [NUM_PATHS*FTW_W-1:0] cal_tone_word
);
   if (NUM_PATHS < 1 || NUM_PATHS > `NTO_PAGE_BITS ||
       FTW_W != 8 * `NTO_FTW_BYTES) begin : g_bad_cfg
      $error("nto_top: unsupported path count or word width");
   end

   logic rst_meta_ff, rst_ff;
   logic [NUM_PATHS-1:0] page_ff, nxt_page;
   nto_byte_t byte_ff [NUM_PATHS][`NTO_FTW_BYTES];
   nto_byte_t nxt_byte [NUM_PATHS][`NTO_FTW_BYTES];
   logic [`NTO_MODE_W-1:0] mode_ff [NUM_PATHS];
   logic [`NTO_MODE_W-1:0] nxt_mode [NUM_PATHS];
   logic [NUM_PATHS-1:0] arm_ff, req_ff, ack_ff, mod_en_ff, rstph_ff;
   logic [NUM_PATHS-1:0] nxt_arm, nxt_req, nxt_ack, nxt_mod_en, nxt_rstph;
   nto_ld_state_t ld_ff [NUM_PATHS];
   nto_ld_state_t nxt_ld [NUM_PATHS];
   logic [FTW_W-1:0] cal_ff [NUM_PATHS];
   logic [FTW_W-1:0] nxt_cal [NUM_PATHS];
   logic [FTW_W-1:0] shadow_w [NUM_PATHS];
   logic [FTW_W-1:0] act_w [NUM_PATHS];
   logic [FTW_W-1:0] phase_w [NUM_PATHS];
   logic [7:0] rd_ff, nxt_rd;
   logic [NUM_PATHS-1:0] trig;
   logic sync_rise;
   logic wr_page, wr_ctrl, wr_update, wr_ftw;
   logic [`NTO_AW-1:0] ftw_off;
   logic [2:0] ftw_idx;

   // The rest of the block sees reset leave only on a clock edge.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_ff <= 1'b0;
         rst_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_ff <= rst_meta_ff;
      end
   end

   nto_sync u_sync (
      .core_clk(core_clk),
      .rst_n(rst_ff),
      .async_in(sync_edge_in),
      .rise(sync_rise)
   );

   assign wr_page = reg_wr_en && reg_addr == `NTO_ADDR_PAGE;
   assign wr_ctrl = reg_wr_en && reg_addr == `NTO_ADDR_NCO_CTRL;
   assign wr_update = reg_wr_en && reg_addr == `NTO_ADDR_UPDATE;
   assign wr_ftw = reg_wr_en && reg_addr >= `NTO_ADDR_FTW0 &&
                   reg_addr <= `NTO_ADDR_FTW5;
   assign ftw_off = reg_addr - `NTO_ADDR_FTW0;
   assign ftw_idx = ftw_off[2:0];

   always_comb begin
      for (int p = 0; p < NUM_PATHS; p++) begin
         for (int b = 0; b < `NTO_FTW_BYTES; b++) begin
            shadow_w[p][b*8 +: 8] = byte_ff[p][b];
         end
      end
   end

   always_comb begin
      nxt_page = page_ff;
      if (wr_page) begin
         nxt_page = reg_wdata[`NTO_PAGE_LSB +: NUM_PATHS];
      end
      for (int p = 0; p < NUM_PATHS; p++) begin
         nxt_byte[p] = byte_ff[p];
         nxt_mode[p] = mode_ff[p];
         nxt_arm[p] = arm_ff[p];
         nxt_req[p] = req_ff[p];
         nxt_ack[p] = ack_ff[p];
         nxt_mod_en[p] = mod_en_ff[p];
         nxt_rstph[p] = rstph_ff[p];
         nxt_ld[p] = ld_ff[p];
         nxt_cal[p] = cal_ff[p];
         trig[p] = 1'b0;
         if (page_ff[p]) begin
            if (wr_ftw) begin
               nxt_byte[p][ftw_idx] = reg_wdata;
               // Mode n fires on byte n-1; mode zero and seven never match.
               if (mode_ff[p] != `NTO_MODE_NONE &&
                   mode_ff[p] == 3'(ftw_idx + `NTO_MODE_BYTE_OFS)) begin
                  trig[p] = 1'b1;
               end
            end
            if (wr_ctrl) begin
               nxt_mod_en[p] = reg_wdata[`NTO_CTRL_MOD_BIT];
            end
            if (wr_update) begin
               nxt_mode[p] = reg_wdata[`NTO_MODE_LSB +: `NTO_MODE_W];
               nxt_arm[p] = reg_wdata[`NTO_UPD_SYNC_BIT];
               nxt_req[p] = reg_wdata[`NTO_UPD_REQ_BIT];
               if (!reg_wdata[`NTO_UPD_REQ_BIT]) begin
                  nxt_ack[p] = 1'b0;
               end else if (!req_ff[p]) begin
                  trig[p] = 1'b1;
               end
            end
         end
         nxt_rstph[p] = 1'b0;
         if (sync_rise && arm_ff[p]) begin
            trig[p] = 1'b1;
            nxt_rstph[p] = 1'b1;
            // The arm is spent by the edge unless software re-arms now.
            if (!(page_ff[p] && wr_update)) begin
               nxt_arm[p] = 1'b0;
            end
         end else if (trig[p]) begin
            nxt_rstph[p] = 1'b0;
         end else begin
            nxt_rstph[p] = rstph_ff[p];
         end
         unique case (ld_ff[p])
            NTO_LD_IDLE: begin
               nxt_ld[p] = NTO_LD_IDLE;
            end
            NTO_LD_XFER: begin
               nxt_cal[p] = shadow_w[p];
               nxt_ld[p] = NTO_LD_DONE;
            end
            NTO_LD_DONE: begin
               nxt_ack[p] = 1'b1;
               nxt_ld[p] = NTO_LD_IDLE;
            end
            default: begin
               nxt_ld[p] = NTO_LD_IDLE;
            end
         endcase
         // A fresh trigger restarts the transfer even mid-sequence.
         if (trig[p]) begin
            nxt_ld[p] = NTO_LD_XFER;
         end
      end
   end

   always_comb begin
      int rp;
      rp = 0;
      for (int p = NUM_PATHS - 1; p >= 0; p--) begin
         if (page_ff[p]) begin
            rp = p;
         end
      end
      nxt_rd = rd_ff;
      if (reg_rd_en) begin
         nxt_rd = `NTO_RST_BYTE;
         if (reg_addr == `NTO_ADDR_PAGE) begin
            nxt_rd[`NTO_PAGE_LSB +: NUM_PATHS] = page_ff;
         end else if (reg_addr == `NTO_ADDR_NCO_CTRL) begin
            nxt_rd[`NTO_CTRL_MOD_BIT] = mod_en_ff[rp];
         end else if (reg_addr == `NTO_ADDR_UPDATE) begin
            nxt_rd[`NTO_MODE_LSB +: `NTO_MODE_W] = mode_ff[rp];
            nxt_rd[`NTO_UPD_SYNC_BIT] = arm_ff[rp];
            nxt_rd[`NTO_UPD_ACK_BIT] = ack_ff[rp];
            nxt_rd[`NTO_UPD_REQ_BIT] = req_ff[rp];
         end else if (wr_ftw || (reg_addr >= `NTO_ADDR_FTW0 &&
                      reg_addr <= `NTO_ADDR_FTW5)) begin
            nxt_rd = byte_ff[rp][ftw_idx];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_ff) begin
      if (!rst_ff) begin
         page_ff <= '0;
         arm_ff <= '0;
         req_ff <= '0;
         ack_ff <= '0;
         mod_en_ff <= '0;
         rstph_ff <= '0;
         rd_ff <= `NTO_RST_BYTE;
         for (int p = 0; p < NUM_PATHS; p++) begin
            mode_ff[p] <= `NTO_MODE_NONE;
            ld_ff[p] <= NTO_LD_IDLE;
            cal_ff[p] <= '0;
            for (int b = 0; b < `NTO_FTW_BYTES; b++) begin
               byte_ff[p][b] <= `NTO_RST_BYTE;
            end
         end
      end else begin
         page_ff <= nxt_page;
         arm_ff <= nxt_arm;
         req_ff <= nxt_req;
         ack_ff <= nxt_ack;
         mod_en_ff <= nxt_mod_en;
         rstph_ff <= nxt_rstph;
         rd_ff <= nxt_rd;
         mode_ff <= nxt_mode;
         ld_ff <= nxt_ld;
         cal_ff <= nxt_cal;
         byte_ff <= nxt_byte;
      end
   end

   assign reg_rd_data = rd_ff;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_ff);

   for (genvar g = 0; g < NUM_PATHS; g++) begin : g_path
      nto_accum #(
         .FTW_W(FTW_W),
         .MOD_W(MOD_W)
      ) u_accum (
         .core_clk(core_clk),
         .rst_n(rst_ff),
         .load_pulse(ld_ff[g] == NTO_LD_XFER),
         .reset_phase(rstph_ff[g]),
         .next_word(shadow_w[g]),
         .modulus_enable(mod_en_ff[g]),
         .acc_delta(acc_delta),
         .acc_modulus(acc_modulus),
         .active_word(act_w[g]),
         .phase(phase_w[g])
      );
      assign nco_phase[g*FTW_W +: FTW_W] = phase_w[g];
      assign main_tuning_word[g*FTW_W +: FTW_W] = act_w[g];
      assign cal_tone_word[g*FTW_W +: FTW_W] = cal_ff[g];

      chk_sw_edge: assert property (
         (wr_update && page_ff[g] && reg_wdata[`NTO_UPD_REQ_BIT] &&
          !req_ff[g]) |=> ld_ff[g] == NTO_LD_XFER)
         else $error("request edge did not start a load");
      chk_auto_none: assert property (
         (wr_ftw && page_ff[g] && mode_ff[g] == `NTO_MODE_NONE &&
          !(sync_rise && arm_ff[g])) |=> ld_ff[g] != NTO_LD_XFER)
         else $error("byte write loaded in mode zero");
      chk_auto_byte: assert property (
         (wr_ftw && page_ff[g] &&
          mode_ff[g] == 3'(ftw_idx + `NTO_MODE_BYTE_OFS)) |=>
         ld_ff[g] == NTO_LD_XFER ##1 act_w[g] == $past(shadow_w[g]))
         else $error("auto mode byte write missed its load");
      chk_sync_load: assert property (
         (sync_rise && arm_ff[g]) |=>
         (ld_ff[g] == NTO_LD_XFER && rstph_ff[g]) ##1 phase_w[g] == '0)
         else $error("sync edge did not load and reset");
      chk_ack_set: assert property (
         (ld_ff[g] == NTO_LD_XFER && !trig[g]) |=> ##1 ack_ff[g])
         else $error("acknowledge not set after load");
      chk_ack_clear: assert property (
         (wr_update && page_ff[g] && !reg_wdata[`NTO_UPD_REQ_BIT] &&
          ld_ff[g] != NTO_LD_DONE) |=> !ack_ff[g])
         else $error("writing zero did not clear acknowledge");
      chk_cal_pair: assert property (
         ld_ff[g] == NTO_LD_DONE |-> cal_ff[g] == act_w[g])
         else $error("calibration word not loaded with main word");
      chk_word_hold: assert property (
         ld_ff[g] != NTO_LD_XFER |=> $stable(act_w[g]))
         else $error("active word changed without a load");
      chk_page_gate: assert property (
         !page_ff[g] |=>
         $stable(shadow_w[g]) && $stable(mode_ff[g]))
         else $error("unselected page was written");
      // These guard the one-shot arm and the ignored repeat request.
      chk_arm_spent: assert property (
         (sync_rise && arm_ff[g] && !(page_ff[g] && wr_update)) |=>
         !arm_ff[g])
         else $error("sync arm not spent by its edge");
      chk_req_refused: assert property (
         (wr_update && page_ff[g] && req_ff[g] &&
          reg_wdata[`NTO_UPD_REQ_BIT] && !(sync_rise && arm_ff[g])) |=>
         ld_ff[g] != NTO_LD_XFER)
         else $error("repeated request bit started a load");
      chk_cal_hold: assert property (
         ld_ff[g] != NTO_LD_XFER |=> $stable(cal_ff[g]))
         else $error("calibration word changed without a load");
      chk_mode_write: assert property (
         (wr_update && page_ff[g]) |=>
         mode_ff[g] == $past(reg_wdata[`NTO_MODE_LSB +: `NTO_MODE_W]))
         else $error("auto update mode not stored");

      cov_sw_load: cover property (
         wr_update && page_ff[g] && reg_wdata[`NTO_UPD_REQ_BIT] &&
         !req_ff[g] ##2 ld_ff[g] == NTO_LD_DONE);
      cov_auto_load: cover property (
         wr_ftw && page_ff[g] && mode_ff[g] != `NTO_MODE_NONE ##1
         ld_ff[g] == NTO_LD_XFER);
      cov_sync_load: cover property (sync_rise && arm_ff[g]);
      cov_ack_clear: cover property (ack_ff[g] ##1 !ack_ff[g]);
      cov_req_refused: cover property (
         wr_update && page_ff[g] && req_ff[g] && reg_wdata[`NTO_UPD_REQ_BIT]);
   end
endmodule

// >>> bench/nto_host.sv
`timescale 1ns/1ps
`include "nto_defines.svh"
module nto_host #(
   parameter int MOD_W = 32
) (
   input wire logic core_clk,
   output logic [`NTO_AW-1:0] reg_addr,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rd_data,
   output logic [MOD_W-1:0] acc_delta,
   output logic [MOD_W-1:0] acc_modulus
);
   initial begin
      reg_addr = 12'hfff;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_wdata = 8'ha5;
      acc_delta = 32'h5;
      acc_modulus = 32'h3;
   end

   // Data is inverted after each write so a stale byte is never mistaken.
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge core_clk);
      reg_wr_en = 1'b0;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge core_clk);
      reg_rd_en = 1'b0;
      d = reg_rd_data;
   endtask

   // A pair that breaks the delta limits is never applied.
   task automatic set_mod(input logic [31:0] m, input logic [31:0] dl);
      if (dl > m && dl != 0) begin
         acc_modulus = m;
         acc_delta = dl;
      end
   endtask
endmodule

// >>> bench/nto_top_tb.sv
`timescale 1ns/1ps
`include "nto_defines.svh"
`define CHK(g, e) chk(48'(g), 48'(e))
module nto_top_tb;
   import nto_pkg::*;
   localparam int W = 48;
   logic core_clk;
   logic reset_n;
   logic sync_edge_in;
   logic [`NTO_AW-1:0] reg_addr;
   logic reg_wr_en;
   logic reg_rd_en;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rd_data;
   logic [31:0] acc_delta;
   logic [31:0] acc_modulus;
   logic [2*W-1:0] nco_phase;
   logic [2*W-1:0] main_tuning_word;
   logic [2*W-1:0] cal_tone_word;
   int num_errors = 0;
   int total_checks = 0;
   integer seed = 32'hd3485ea9;
   nto_byte_t shadow [2][6];
   logic [W-1:0] active [2];
   logic [7:0] rdv;
   logic [31:0] md;
   int cyc = 0;
   int en_cyc = 0;

   nto_top #(.NUM_PATHS(2), .FTW_W(W), .MOD_W(32)) u_nto_top (
      .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data),
      .sync_edge_in(sync_edge_in), .acc_delta(acc_delta),
      .acc_modulus(acc_modulus), .nco_phase(nco_phase),
      .main_tuning_word(main_tuning_word), .cal_tone_word(cal_tone_word));

   nto_host #(.MOD_W(32)) u_nto_host (
      .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
      .reg_rd_data(reg_rd_data), .acc_delta(acc_delta),
      .acc_modulus(acc_modulus));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   always @(posedge core_clk) cyc <= cyc + 1;

   function automatic logic [W-1:0] word_of(input int p);
      logic [W-1:0] w;
      for (int k = 0; k < 6; k++) w[k*8+:8] = shadow[p][k];
      return w;
   endfunction

   task automatic chk(input logic [W-1:0] g, input logic [W-1:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic check_words();
      for (int p = 0; p < 2; p++) begin
         `CHK(main_tuning_word[p*W+:W], active[p]);
         `CHK(cal_tone_word[p*W+:W], active[p]);
      end
   endtask

   task automatic put_byte(input int p, input int k);
      logic [7:0] d;
      d = 8'($random(seed));
      u_nto_host.wr(12'(`NTO_ADDR_FTW0 + k), d);
      shadow[p][k] = d;
   endtask

   task automatic sync_pulse();
      sync_edge_in = 1'b1;
      wait_n(2);
      sync_edge_in = 1'b0;
   endtask

   // Whole carries of the next edge, n modulus steps after enabling.
   function automatic logic [W-1:0] mod_carry(input int n);
      longint unsigned f;
      f = (longint'(n) * acc_delta) % acc_modulus;
      return W'((f + acc_delta) / acc_modulus);
   endfunction

   task automatic step_check(input int p, input logic [W-1:0] word,
                             input bit mod_on);
      logic [W-1:0] p0;
      logic [W-1:0] inc;
      @(negedge core_clk);
      p0 = nco_phase[p*W+:W];
      inc = word;
      if (mod_on) inc = word + mod_carry(cyc - en_cyc);
      @(negedge core_clk);
      `CHK(nco_phase[p*W+:W] - p0, inc);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #(40 * 4000);
      num_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      close_out();
   end

   initial begin
      sync_edge_in = 1'b0;
      reset_n = 1'b0;
      for (int p = 0; p < 2; p++) begin
         active[p] = '0;
         for (int k = 0; k < 6; k++) shadow[p][k] = 8'h00;
      end
      wait_n(3);
      reset_n = 1'b1;
      wait_n(4);
      u_nto_host.rd(`NTO_ADDR_UPDATE, rdv);
      `CHK(rdv, 8'h00);
      u_nto_host.wr(12'h200, 8'h5a);
      u_nto_host.rd(12'h200, rdv);
      `CHK(rdv, 8'h00);
      check_words();
      $display("test reset done");

      u_nto_host.wr(`NTO_ADDR_PAGE, 8'h40);
      for (int k = 0; k < 6; k++) put_byte(0, k);
      wait_n(3);
      check_words();
      u_nto_host.rd(`NTO_ADDR_FTW0, rdv);
      `CHK(rdv, shadow[0][0]);
      u_nto_host.wr(`NTO_ADDR_UPDATE, 8'h01);
      active[0] = word_of(0);
      wait_n(2);
      check_words();
      wait_n(1);
      u_nto_host.rd(`NTO_ADDR_UPDATE, rdv);
      `CHK(rdv, 8'h03);
      put_byte(0, 0);
      u_nto_host.wr(`NTO_ADDR_UPDATE, 8'h01);
      wait_n(3);
      check_words();
      u_nto_host.wr(`NTO_ADDR_UPDATE, 8'h00);
      u_nto_host.rd(`NTO_ADDR_UPDATE, rdv);
      `CHK(rdv, 8'h00);
      $display("test software load done");

      for (int m = 1; m <= 7; m++) begin
         u_nto_host.wr(`NTO_ADDR_UPDATE, 8'(m << 4));
         put_byte(0, m % 6);
         wait_n(3);
         check_words();
         put_byte(0, (m + 5) % 6);
         if (m <= 6) active[0] = word_of(0);
         wait_n(2);
         check_words();
         wait_n(1);
         u_nto_host.rd(`NTO_ADDR_UPDATE, rdv);
         `CHK(rdv, 8'(m << 4) | (m <= 6 ? 8'h02 : 8'h00));
      end
      $display("test auto modes done");

      u_nto_host.wr(`NTO_ADDR_PAGE, 8'h80);
      u_nto_host.rd(`NTO_ADDR_UPDATE, rdv);
      `CHK(rdv, 8'h00);
      u_nto_host.wr(`NTO_ADDR_UPDATE, 8'h10);
      put_byte(1, 0);
      active[1] = word_of(1);
      wait_n(2);
      check_words();
      $display("test paging done");

      u_nto_host.wr(`NTO_ADDR_PAGE, 8'h40);
      u_nto_host.wr(`NTO_ADDR_UPDATE, 8'h04);
      put_byte(0, 2);
      wait_n(8);
      check_words();
      sync_pulse();
      active[0] = word_of(0);
      wait_n(8);
      check_words();
      u_nto_host.rd(`NTO_ADDR_UPDATE, rdv);
      `CHK(rdv, 8'h02);
      put_byte(0, 3);
      sync_pulse();
      wait_n(10);
      check_words();
      $display("test sync load done");

      step_check(0, active[0], 1'b0);
      step_check(1, active[1], 1'b0);
      md = 32'd1000 + 32'($unsigned($random(seed)) % 1000);
      u_nto_host.set_mod(md, md + 1 + 32'($unsigned($random(seed)) % (md - 1)));
      u_nto_host.wr(`NTO_ADDR_NCO_CTRL, 8'h04);
      en_cyc = cyc;
      u_nto_host.rd(`NTO_ADDR_NCO_CTRL, rdv);
      `CHK(rdv, 8'h04);
      step_check(0, active[0], 1'b1);
      step_check(0, active[0], 1'b1);
      u_nto_host.wr(`NTO_ADDR_NCO_CTRL, 8'h00);
      wait_n(2);
      step_check(0, active[0], 1'b0);
      $display("test accumulation done");
      close_out();
   end
endmodule
